// ### logic/adcc_pkg.sv
/*
 * Constants, register map and state type of the A/D conversion control.
 * Assumes a 32-bit AXI4-Lite register bus and one 200 MHz system clock.
 */
package adcc_pkg;

   // Bus geometry and responses
   localparam int AXI_ADDR_W = 8;
   localparam int AXI_DATA_W = 32;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Register byte offsets
   localparam logic [7:0] OFF_PIN_LOW = 8'h00;
   localparam logic [7:0] OFF_PIN_HIGH = 8'h04;
   localparam logic [7:0] OFF_CTL0 = 8'h08;
   localparam logic [7:0] OFF_CTL1 = 8'h0c;
   localparam logic [7:0] OFF_RES_LOW = 8'h10;
   localparam logic [7:0] OFF_RES_HIGH = 8'h14;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;

   // Field widths and positions
   localparam int PIN_LOW_W = 8;
   localparam int PIN_HIGH_W = 4;
   localparam int PIN_W = PIN_LOW_W + PIN_HIGH_W;
   localparam int CHAN_W = 5;
   localparam int DIV_W = 3;
   localparam int RESULT_W = 12;
   localparam int RES_LOW_W = 8;
   localparam int RES_HIGH_W = RESULT_W - RES_LOW_W;
   localparam int CTL0_START_BIT = 7;
   localparam int CTL0_BUSY_BIT = 6;
   localparam int CTL0_POWER_OFF_BIT = 5;
   localparam int CTL0_CHAN_LSB = 0;
   localparam int CTL1_REF_BIT = 4;
   localparam int CTL1_DIV_LSB = 0;
   localparam int IRQ_DONE_BIT = 0;

   // Reset values
   localparam logic [PIN_LOW_W-1:0] PIN_LOW_RESET = 8'hff;
   localparam logic [PIN_HIGH_W-1:0] PIN_HIGH_RESET = 4'hf;
   localparam logic POWER_OFF_RESET = 1'b1;
   localparam logic [CHAN_W-1:0] CHAN_RESET = 5'h00;
   localparam logic [DIV_W-1:0] DIV_RESET = 3'h0;

   // Clock division and conversion length
   localparam logic [DIV_W-1:0] DIV_UNDEFINED = 3'h7;
   localparam int DIV_CNT_W = 6;
   localparam int CONV_PERIODS = 16;
   localparam int CONV_CNT_W = 5;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_HELD,
      ST_CONV
   } adcc_state_type;

endpackage

// ### logic/adcc_div_if.sv
/*
 * Link between the conversion sequencer and the A/D clock divider.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface adcc_div_if;
   logic [adcc_pkg::DIV_W-1:0] div_sel;
   logic run;
   logic tick;
   modport div (input div_sel, input run, output tick);
   modport ctl (output div_sel, output run, input tick);
endinterface
`default_nettype wire

// ### logic/adcc_clkdiv.sv
/*
 * A/D clock divider: one tick per A/D clock period while running.
 * Assumes run rises on the launch of a conversion, so periods align to it.
 */
`timescale 1ns/1ps
`default_nettype none
module adcc_clkdiv #(
   parameter int CNT_W = adcc_pkg::DIV_CNT_W
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Sequencer side
   adcc_div_if.div div
);
   import adcc_pkg::*;

   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic [CNT_W:0] mask_wide;
   logic [CNT_W-1:0] mask;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      mask_wide = ({{CNT_W{1'b0}}, 1'b1} << div.div_sel)
                  - {{CNT_W{1'b0}}, 1'b1};
      mask = mask_wide[CNT_W-1:0];
      next_cnt = div.run ? cnt + {{(CNT_W-1){1'b0}}, 1'b1} : '0;
      // Undefined select gives no ticks, so a conversion stalls busy
      div.tick = div.run && (div.div_sel != DIV_UNDEFINED)
                 && ((cnt & mask) == mask);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end

endmodule
`default_nettype wire

// ### logic/adcc_top.sv
/*
 * A/D conversion control: pin selection, start/reset protocol, busy flag,
 * completion interrupt, A/D clock divider, power and reference control,
 * all behind an AXI4-Lite slave.
 * Assumes the analog core, pin muxes and pads sit outside on aclk.
 */
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
// Operation
// - Low pin-select bits route port A pins to channels 0-7, reset ones.
// - High pin-select bits 0-3 route four pins to channels 8-11, reset ones.
// - High pin-select bits 7-4 are unimplemented and read zero.
// - Conversion launches when software completes a low-high-low start pulse.
// - Start held high after rising keeps converter reset and busy high.
// - Busy flag clears automatically when a conversion finishes.
// - Conversion end sets interrupt request; enabled request raises interrupt.
// - A/D clock is system clock divided by 1 to 64; code 111 undefined.
// - Converter is powered only while the power-off bit is zero.
// - Reference select picks supply or reference pin, disabling pin functions.
// - A conversion takes sixteen A/D clock periods.
// - Result is twelve bits, read from low and high result registers.
// - Analog pins drop pull-highs and override port direction.
// - A five-bit field selects the channel fed to the converter.
`timescale 1ns/1ps
`default_nettype none
module adcc_top (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [adcc_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [adcc_pkg::AXI_DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [adcc_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [adcc_pkg::AXI_DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Interrupt
   output logic irq,
   // Analog core
   output logic core_power_on,
   output logic core_reset,
   output logic core_converting,
   output logic core_clock_tick,
   output logic [adcc_pkg::CHAN_W-1:0] core_channel_select,
   input wire logic [adcc_pkg::RESULT_W-1:0] core_result,
   // Pin and reference control
   output logic [adcc_pkg::PIN_W-1:0] pin_analog_enable_bits,
   output logic [adcc_pkg::PIN_W-1:0] pin_pullup_disconnect,
   output logic [adcc_pkg::PIN_W-1:0] pin_direction_override,
   output logic reference_source_select,
   output logic ref_pin_other_func_disable
);
   import adcc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Register state
   logic [PIN_LOW_W-1:0] pin_low, next_pin_low;
   logic [PIN_HIGH_W-1:0] pin_high, next_pin_high;
   logic ctl_start, next_ctl_start;
   logic power_off, next_power_off;
   logic [CHAN_W-1:0] chan, next_chan;
   logic [DIV_W-1:0] div_sel, next_div_sel;
   logic ref_sel, next_ref_sel;
   logic [RESULT_W-1:0] result, next_result;
   logic irq_stat, next_irq_stat;
   logic irq_mask, next_irq_mask;
   // Bus state
   logic aw_held, next_aw_held;
   logic [AXI_ADDR_W-1:0] aw_addr, next_aw_addr;
   logic w_held, next_w_held;
   logic [AXI_DATA_W-1:0] w_data, next_w_data;
   logic w_strb0, next_w_strb0;
   logic bvalid, next_bvalid;
   logic [1:0] bresp, next_bresp;
   logic rvalid, next_rvalid;
   logic [AXI_DATA_W-1:0] rdata, next_rdata;
   logic [1:0] rresp, next_rresp;
   // Sequencer state
   adcc_state_type state, next_state;
   logic [CONV_CNT_W-1:0] conv_cnt, next_conv_cnt;
   logic start_prev, next_start_prev;
   // Combinational helpers
   logic start_rise;
   logic conv_done;
   logic busy;
   logic wr_fire;
   logic [AXI_ADDR_W-1:0] wr_addr;
   logic [AXI_ADDR_W-1:0] rd_addr;
   logic [AXI_DATA_W-1:0] rd_word;
   logic rd_ok;
   logic [PIN_LOW_W-1:0] wbyte;

   adcc_div_if div_link ();

   adcc_clkdiv #(
      .CNT_W(DIV_CNT_W)
   ) u_clkdiv (
      .aclk(aclk),
      .aresetn(aresetn),
      .div(div_link)
   );

   ////////////////////////////////////////////////////////////////////////
   // Conversion sequencer
   assign start_rise = ctl_start && !start_prev;
   assign div_link.div_sel = div_sel;
   // Power-off stops the divider in the same cycle, not one cycle later
   assign div_link.run = (state == ST_CONV) && !power_off;

   always_comb begin
      next_state = state;
      next_conv_cnt = conv_cnt;
      next_start_prev = ctl_start;
      conv_done = 1'b0;
      case (state)
         ST_IDLE: begin
            if (start_rise) begin
               next_state = ST_HELD;
            end
         end
         ST_HELD: begin
            if (!ctl_start) begin
               next_state = ST_CONV;
               next_conv_cnt = '0;
            end
         end
         ST_CONV: begin
            if (start_rise) begin
               // A new start pulse aborts the running conversion
               next_state = ST_HELD;
            end else if (div_link.tick) begin
               if (conv_cnt == CONV_CNT_W'(CONV_PERIODS - 1)) begin
                  next_state = ST_IDLE;
                  conv_done = 1'b1;
               end else begin
                  next_conv_cnt = conv_cnt + CONV_CNT_W'(1);
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      if (power_off) begin
         next_state = ST_IDLE;
         conv_done = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= ST_IDLE;
         conv_cnt <= '0;
         start_prev <= 1'b0;
      end else begin
         state <= next_state;
         conv_cnt <= next_conv_cnt;
         start_prev <= next_start_prev;
      end
   end

   assign busy = (state != ST_IDLE);

   ////////////////////////////////////////////////////////////////////////
   // Register read mux
   assign rd_addr = {s_axi_araddr[AXI_ADDR_W-1:2], 2'h0};

   always_comb begin
      rd_word = '0;
      rd_ok = 1'b1;
      case (rd_addr)
         OFF_PIN_LOW: rd_word[PIN_LOW_W-1:0] = pin_low;
         OFF_PIN_HIGH: rd_word[PIN_HIGH_W-1:0] = pin_high;
         OFF_CTL0: begin
            rd_word[CTL0_START_BIT] = ctl_start;
            rd_word[CTL0_BUSY_BIT] = busy;
            rd_word[CTL0_POWER_OFF_BIT] = power_off;
            rd_word[CTL0_CHAN_LSB +: CHAN_W] = chan;
         end
         OFF_CTL1: begin
            rd_word[CTL1_REF_BIT] = ref_sel;
            rd_word[CTL1_DIV_LSB +: DIV_W] = div_sel;
         end
         OFF_RES_LOW: rd_word[RES_LOW_W-1:0] = result[RES_LOW_W-1:0];
         OFF_RES_HIGH: begin
            rd_word[RES_HIGH_W-1:0] = result[RESULT_W-1:RES_LOW_W];
         end
         OFF_IRQ_STAT: rd_word[IRQ_DONE_BIT] = irq_stat;
         OFF_IRQ_MASK: rd_word[IRQ_DONE_BIT] = irq_mask;
         default: rd_ok = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus slave and registers
   assign s_axi_awready = !aw_held;
   assign s_axi_wready = !w_held;
   assign s_axi_arready = !rvalid;
   assign wr_fire = aw_held && w_held && !bvalid;
   assign wr_addr = {aw_addr[AXI_ADDR_W-1:2], 2'h0};
   assign wbyte = w_data[PIN_LOW_W-1:0];

   always_comb begin
      next_pin_low = pin_low;
      next_pin_high = pin_high;
      next_ctl_start = ctl_start;
      next_power_off = power_off;
      next_chan = chan;
      next_div_sel = div_sel;
      next_ref_sel = ref_sel;
      next_result = result;
      next_irq_stat = irq_stat;
      next_irq_mask = irq_mask;
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_data = w_data;
      next_w_strb0 = w_strb0;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      if (s_axi_awvalid && !aw_held) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb0 = s_axi_wstrb[0];
      end
      if (bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (wr_fire) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = RESP_OKAY;
         // All fields sit in byte lane 0; other lanes are ignored
         case (wr_addr)
            OFF_PIN_LOW: begin
               if (w_strb0) begin
                  next_pin_low = wbyte;
               end
            end
            OFF_PIN_HIGH: begin
               if (w_strb0) begin
                  next_pin_high = wbyte[PIN_HIGH_W-1:0];
               end
            end
            OFF_CTL0: begin
               if (w_strb0) begin
                  next_ctl_start = wbyte[CTL0_START_BIT];
                  next_power_off = wbyte[CTL0_POWER_OFF_BIT];
                  next_chan = wbyte[CTL0_CHAN_LSB +: CHAN_W];
               end
            end
            OFF_CTL1: begin
               if (w_strb0) begin
                  next_ref_sel = wbyte[CTL1_REF_BIT];
                  next_div_sel = wbyte[CTL1_DIV_LSB +: DIV_W];
               end
            end
            OFF_IRQ_MASK: begin
               if (w_strb0) begin
                  next_irq_mask = wbyte[IRQ_DONE_BIT];
               end
            end
            OFF_RES_LOW, OFF_RES_HIGH, OFF_IRQ_STAT: begin
               next_bresp = RESP_OKAY;
            end
            default: next_bresp = RESP_SLVERR;
         endcase
      end
      if (rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && !rvalid) begin
         next_rvalid = 1'b1;
         next_rdata = rd_word;
         next_rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
         if (rd_addr == OFF_IRQ_STAT) begin
            next_irq_stat = 1'b0;
         end
      end
      if (conv_done) begin
         next_result = core_result;
         next_irq_stat = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_low <= PIN_LOW_RESET;
         pin_high <= PIN_HIGH_RESET;
         ctl_start <= 1'b0;
         power_off <= POWER_OFF_RESET;
         chan <= CHAN_RESET;
         div_sel <= DIV_RESET;
         ref_sel <= 1'b0;
         result <= '0;
         irq_stat <= 1'b0;
         irq_mask <= 1'b0;
         aw_held <= 1'b0;
         aw_addr <= '0;
         w_held <= 1'b0;
         w_data <= '0;
         w_strb0 <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end else begin
         pin_low <= next_pin_low;
         pin_high <= next_pin_high;
         ctl_start <= next_ctl_start;
         power_off <= next_power_off;
         chan <= next_chan;
         div_sel <= next_div_sel;
         ref_sel <= next_ref_sel;
         result <= next_result;
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_data <= next_w_data;
         w_strb0 <= next_w_strb0;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign s_axi_bvalid = bvalid;
   assign s_axi_bresp = bresp;
   assign s_axi_rvalid = rvalid;
   assign s_axi_rdata = rdata;
   assign s_axi_rresp = rresp;
   assign irq = irq_stat && irq_mask;
   assign core_power_on = !power_off;
   assign core_reset = (state == ST_HELD) || power_off;
   assign core_converting = (state == ST_CONV) && !power_off;
   assign core_clock_tick = div_link.tick;
   assign core_channel_select = chan;
   assign pin_analog_enable_bits = {pin_high, pin_low};
   assign pin_pullup_disconnect = {pin_high, pin_low};
   assign pin_direction_override = {pin_high, pin_low};
   assign reference_source_select = ref_sel;
   assign ref_pin_other_func_disable = ref_sel;

endmodule
`default_nettype wire

// ### sim/adcc_monitor.sv
/* Port checker of the A/D conversion control.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module adcc_monitor (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Analog core
   input wire logic core_power_on,
   input wire logic core_reset,
   input wire logic core_converting,
   input wire logic core_clock_tick,
   // Pins and reference
   input wire logic [adcc_pkg::PIN_W-1:0] pin_analog_enable_bits,
   input wire logic [adcc_pkg::PIN_W-1:0] pin_pullup_disconnect,
   input wire logic [adcc_pkg::PIN_W-1:0] pin_direction_override,
   input wire logic reference_source_select,
   input wire logic ref_pin_other_func_disable
);
   import adcc_pkg::*;
   logic [5:0] tick_count;
   logic [5:0] next_tick_count;
   default clocking mon_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   ///////////////////////////////////////////////////////////////
   // Ticks of the running conversion; cleared between conversions
   always_comb begin
      next_tick_count = tick_count;
      if (!core_converting)
         next_tick_count = 6'h00;
      else if (core_clock_tick)
         next_tick_count = tick_count + 6'h01;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn)
         tick_count <= 6'h00;
      else
         tick_count <= next_tick_count;
   end
   ///////////////////////////////////////////////////////////////
   // pins come up analog
   a_pins_reset_ones: assert property (
      $rose(aresetn) |-> pin_analog_enable_bits == 12'hfff)
      else $error("pin select not all ones after reset");
   a_pullup_follows: assert property (
      pin_pullup_disconnect == pin_analog_enable_bits &&
      pin_direction_override == pin_analog_enable_bits)
      else $error("pin overrides differ from analog selection");
   a_ref_pin_release: assert property (
      ref_pin_other_func_disable == reference_source_select)
      else $error("reference pin functions not released");
   a_power_off_reset: assert property (
      !core_power_on |-> core_reset && !core_converting)
      else $error("core active while powered off");
   a_tick_in_conv: assert property (
      core_clock_tick |-> core_converting)
      else $error("clock tick outside conversion");
   a_conv_not_reset: assert property (
      core_converting |-> !core_reset)
      else $error("converting while held in reset");
   a_busy_min_len: assert property (
      $rose(core_converting) |-> (core_converting || core_reset) [*8])
      else $error("conversion ended too early");
   a_sixteen_ticks: assert property (
      $fell(core_converting) && !core_reset |-> tick_count == 6'h10)
      else $error("conversion did not last sixteen periods");
endmodule
bind adcc_top adcc_monitor adcc_monitor_inst (
   .aclk, .aresetn, .core_power_on, .core_reset, .core_converting,
   .core_clock_tick, .pin_analog_enable_bits, .pin_pullup_disconnect,
   .pin_direction_override, .reference_source_select,
   .ref_pin_other_func_disable
);
`default_nettype wire

// ### sim/adcc_core_model.sv
/* Behavioural analog core and input pins.
   Assumes the bench sets the pin level before each launch. */
`timescale 1ns/1ps
`default_nettype none
module adcc_core_model (
   // Control from the converter
   input wire logic core_power_on,
   input wire logic core_converting,
   input wire logic [adcc_pkg::CHAN_W-1:0] core_channel_select,
   // Level on the pins
   input wire logic [adcc_pkg::RESULT_W-1:0] level,
   // Code to the converter
   output logic [adcc_pkg::RESULT_W-1:0] core_result
);
   import adcc_pkg::*;
   // code only when powered
   // Outside a conversion the code is inverted so a stray capture shows
   always_comb begin
      if (core_power_on && core_converting)
         core_result = level ^ RESULT_W'(core_channel_select);
      else
         core_result = ~level;
   end
endmodule
`default_nettype wire

// ### sim/test_adc_conversion_control.sv
/* Bench of the A/D conversion control over AXI4-Lite.
   Assumes the core model and the bound port checker. */
`timescale 1ns/1ps
`default_nettype none
module test_adc_conversion_control;
   import adcc_pkg::*;
   logic aclk;
   logic aresetn;
   logic [7:0] s_axi_awaddr;
   logic s_axi_awvalid;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_wvalid;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready;
   logic [7:0] s_axi_araddr;
   logic s_axi_arvalid;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready;
   logic irq;
   logic core_power_on;
   logic core_reset;
   logic core_converting;
   logic core_clock_tick;
   logic [CHAN_W-1:0] core_channel_select;
   logic [RESULT_W-1:0] core_result;
   logic [PIN_W-1:0] pin_analog_enable_bits;
   logic [PIN_W-1:0] pin_pullup_disconnect;
   logic [PIN_W-1:0] pin_direction_override;
   logic reference_source_select;
   logic ref_pin_other_func_disable;
   logic [RESULT_W-1:0] level;
   logic [RESULT_W-1:0] expect_code;
   logic [31:0] rd;
   logic [1:0] resp;
   int n_mismatch = 0;
   int total_checks = 0;
   int cycles = 0;
   int conv_cycles = 0;
   int c0;
   int polls;
   adcc_top adcc_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .core_power_on,
      .core_reset, .core_converting, .core_clock_tick,
      .core_channel_select, .core_result, .pin_analog_enable_bits,
      .pin_pullup_disconnect, .pin_direction_override,
      .reference_source_select, .ref_pin_other_func_disable);
   adcc_core_model adcc_core_model_inst (.core_power_on, .core_converting,
      .core_channel_select, .level, .core_result);
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   // Whole run is near 2500 cycles; the ceiling leaves ample room
   always @(posedge aclk) begin
      cycles++;
      if (core_converting === 1'b1)
         conv_cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         results();
      end
   end
   ///////////////////////////////////////////////////////////////
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Both tasks end half a cycle after the answer so outputs are settled
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
            break;
      end
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(negedge aclk);
      check(32'(resp), 32'(RESP_OKAY));
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid)
            break;
      end
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(negedge aclk);
   endtask
   task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
      rd_reg(a);
      check(rd, exp);
   endtask
   ///////////////////////////////////////////////////////////////
   initial begin
      aresetn = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 8'h00;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      level = 12'h000;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      reg_check(OFF_PIN_LOW, 32'hff);
      reg_check(OFF_PIN_HIGH, 32'h0f);
      check(32'(pin_analog_enable_bits), 32'hfff);
      wr(OFF_PIN_HIGH, 32'hffff_ffa5);
      reg_check(OFF_PIN_HIGH, 32'h05);
      wr(OFF_PIN_LOW, 32'h3c);
      reg_check(OFF_PIN_LOW, 32'h3c);
      check(32'(pin_analog_enable_bits), 32'h53c);
      check(32'(pin_direction_override), 32'h53c);
      check(32'(pin_pullup_disconnect), 32'h53c);
      rd_reg(8'h20);
      check(32'(resp), 32'(RESP_SLVERR));
      reg_check(OFF_CTL0, 32'h20);
      check(32'(core_power_on), 32'h0);
      wr(OFF_CTL1, 32'h10);
      check(32'(ref_pin_other_func_disable), 32'h1);
      check(32'(reference_source_select), 32'h1);
      wr(OFF_CTL0, 32'h05);
      check(32'(core_power_on), 32'h1);
      check(32'(core_channel_select), 32'h05);
      repeat (20) @(posedge aclk);
      // the period minimum is the analog core's; any defined code runs here
      // Divider codes 0 to 6; odd codes with the interrupt unmasked
      for (int div = 0; div < 7; div++) begin
         wr(OFF_IRQ_MASK, 32'(div % 2));
         wr(OFF_CTL1, 32'h10 + 32'(div));
         expect_code = (div == 6) ? 12'hfff : 12'h5a0 + 12'(div);
         level <= expect_code ^ 12'h005;
         c0 = conv_cycles;
         wr(OFF_CTL0, 32'h85);
         reg_check(OFF_CTL0, 32'hc5);
         check(32'(core_reset), 32'h1);
         check(32'(conv_cycles - c0), 32'h0);
         wr(OFF_CTL0, 32'h05);
         polls = 0;
         do begin
            rd_reg(OFF_CTL0);
            polls++;
         end while (rd[6] !== 1'b0 && polls < 600);
         check(rd, 32'h05);
         check(32'(conv_cycles - c0), 32'(16 << div));
         check(32'(irq), 32'(div % 2));
         reg_check(OFF_RES_LOW, 32'(expect_code[7:0]));
         reg_check(OFF_RES_HIGH, 32'(expect_code[11:8]));
         reg_check(OFF_IRQ_STAT, 32'h1);
         check(32'(irq), 32'h0);
      end
      // Undefined divider stalls busy; a start rise or power-off aborts it
      wr(OFF_CTL1, 32'h17);
      wr(OFF_CTL0, 32'h85);
      wr(OFF_CTL0, 32'h05);
      repeat (100) @(posedge aclk);
      reg_check(OFF_CTL0, 32'h45);
      check(32'(core_converting), 32'h1);
      wr(OFF_CTL0, 32'h85);
      reg_check(OFF_CTL0, 32'hc5);
      check(32'(core_reset), 32'h1);
      wr(OFF_CTL0, 32'h05);
      wr(OFF_CTL0, 32'h25);
      check(32'(core_reset), 32'h1);
      check(32'(core_converting), 32'h0);
      reg_check(OFF_CTL0, 32'h25);
      reg_check(OFF_IRQ_STAT, 32'h0);
      results();
   end
endmodule
`default_nettype wire
